// File: src/bct_pkg.sv
// Package and condition evaluator for the branch-condition and bit-test unit.
//
// Function
// - Branch higher-or-same (0x24) is taken only when carry is clear.
// - Branch pin-high (0x2f) samples the interrupt pin, taken when it is high.
// - Branch pin-low (0x2e) samples the interrupt pin, taken when it is low.
// - Bit test ANDs accumulator and operand, drops it, clears V, sets N=bit 7.
// - Bit test sets Z when the AND is zero and alters neither A nor operand.
// - Branch signed-less-equal (0x93) is taken when Z is set or N differs V.
// - Branch unsigned-lower (0x25) is taken only when carry is set.
// - Branch unsigned-lower-same (0x23) is taken when carry or zero is set.
// - Branch signed-less (0x91) is taken when N and V differ.
// - Branch mask-clear (0x2c) is taken only when the interrupt mask is 0.
// - A taken branch adds the sign-extended offset to form the next address.
// - A branch not taken continues after the two-byte instruction.

package bct_pkg;

    // ---------------------------------------------------------------
    // Register map
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_FLAGS = 8'h00;
    localparam logic [7:0] ADDR_PC = 8'h04;
    localparam logic [7:0] ADDR_ACC = 8'h08;
    localparam logic [7:0] ADDR_OPND = 8'h0c;
    localparam logic [7:0] ADDR_CMD = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    localparam logic [2:0] SIZE_WORD = 3'h2;

    localparam int STAT_BUSY = 0;
    localparam int STAT_TAKEN = 1;
    localparam int STAT_OVERRUN = 2;
    localparam int STAT_ILLEGAL = 3;

    // ---------------------------------------------------------------
    // Opcodes and timing
    // ---------------------------------------------------------------
    localparam logic [7:0] OP_HIGHER_SAME = 8'h24;
    localparam logic [7:0] OP_UNSIGNED_LOWER = 8'h25;
    localparam logic [7:0] OP_LOWER_SAME = 8'h23;
    localparam logic [7:0] OP_SIGNED_LESS = 8'h91;
    localparam logic [7:0] OP_SIGNED_LESS_EQUAL = 8'h93;
    localparam logic [7:0] OP_MASK_CLEAR = 8'h2c;
    localparam logic [7:0] OP_PIN_HIGH = 8'h2f;
    localparam logic [7:0] OP_PIN_LOW = 8'h2e;
    localparam logic [3:0] OP_BIT_LOW = 4'h5;
    localparam logic [3:0] OP_BIT_HI_MIN = 4'ha;

    localparam logic [1:0] BRANCH_CYCLES = 2'h3;
    localparam logic [1:0] BIT_CYCLES = 2'h2;
    localparam logic [15:0] INSN_LEN = 16'h0002;

    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    localparam logic [7:0] FLAGS_RST = 8'h60;
    localparam logic [7:0] FLAGS_ONES = 8'h60;
    localparam logic [15:0] PC_RST = 16'h0000;

    // ---------------------------------------------------------------
    // Types
    // ---------------------------------------------------------------
    typedef struct packed {
        logic v;
        logic one6;
        logic one5;
        logic h;
        logic i;
        logic n;
        logic z;
        logic c;
    } bct_ccr_s;

    typedef struct packed {
        logic [7:0] rel;
        logic [7:0] op;
    } bct_cmd_s;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01
    } bct_state_e;

    typedef struct packed {
        bct_state_e state;
        logic [1:0] cnt;
        bct_ccr_s flags;
        logic [15:0] pc;
        logic [7:0] acc;
        logic [7:0] opnd;
        bct_cmd_s cmd;
        logic pin;
        logic is_bit;
        logic busy;
        logic done;
        logic taken;
        logic overrun;
        logic illegal;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] rdata;
        logic ready;
        logic resp;
    } bct_core_s;

    localparam bct_core_s CORE_RST = '{
        state: ST_IDLE,
        cnt: 2'h0,
        flags: bct_ccr_s'(FLAGS_RST),
        pc: PC_RST,
        acc: 8'h00,
        opnd: 8'h00,
        cmd: 16'h0000,
        wr_addr: 8'h00,
        rdata: 32'h0000_0000,
        ready: 1'b1,
        default: 1'b0
    };

    // ---------------------------------------------------------------
    // Decode helpers
    // ---------------------------------------------------------------
    function automatic logic is_branch_op(input logic [7:0] op);
        return (op == OP_HIGHER_SAME) || (op == OP_UNSIGNED_LOWER) ||
               (op == OP_LOWER_SAME) || (op == OP_SIGNED_LESS) ||
               (op == OP_SIGNED_LESS_EQUAL) || (op == OP_MASK_CLEAR) ||
               (op == OP_PIN_HIGH) || (op == OP_PIN_LOW);
    endfunction

    // All addressing forms share one operand register here.
    function automatic logic is_bit_op(input logic [7:0] op);
        return (op[3:0] == OP_BIT_LOW) && (op[7:4] >= OP_BIT_HI_MIN);
    endfunction

    function automatic logic [15:0] sext8(input logic [7:0] rel);
        return {{8{rel[7]}}, rel};
    endfunction

endpackage

// File: src/bct_cond.sv
// Branch condition evaluator: decides whether a decoded branch is taken.
`timescale 1ns/1ns

module bct_cond (
    // Instruction and machine state
    input wire logic [7:0] op,
    input wire bct_pkg::bct_ccr_s flags,
    input wire logic pin,
    // Decision
    output logic take
);

    always_comb begin
        take = 1'b0;
        case (op)
            bct_pkg::OP_HIGHER_SAME: take = !flags.c;
            bct_pkg::OP_PIN_HIGH: take = pin;
            bct_pkg::OP_PIN_LOW: take = !pin;
            bct_pkg::OP_SIGNED_LESS_EQUAL: begin
                take = flags.z || (flags.n ^ flags.v);
            end
            bct_pkg::OP_UNSIGNED_LOWER: take = flags.c;
            bct_pkg::OP_LOWER_SAME: take = flags.c || flags.z;
            bct_pkg::OP_SIGNED_LESS: take = flags.n ^ flags.v;
            bct_pkg::OP_MASK_CLEAR: take = !flags.i;
            // Non-branch codes never take; the caller filters them.
            default: take = 1'b0;
        endcase
    end

endmodule // bct_cond

// File: src/bct_top.sv
// Branch-condition and bit-test execution unit with an AHB-Lite slave.
//
// Design decisions made here: register access over AHB-Lite and the address map.
`timescale 1ns/1ns

module bct_top (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RST_N,
    // AHB-Lite slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // Core side
    input wire logic IRQ_PIN,
    output logic BUSY,
    output logic BRANCH_DONE,
    output logic BRANCH_TAKEN,
    output logic [15:0] NEXT_PC
);

    // ---------------------------------------------------------------
    // State and decode
    // ---------------------------------------------------------------
    bct_pkg::bct_core_s s_q;
    bct_pkg::bct_core_s s_d;
    logic take;
    logic addr_ok;
    logic go;
    logic [7:0] new_op;
    logic [7:0] and_res;

    bct_cond u_cond (
        .op(s_q.cmd.op),
        .flags(s_q.flags),
        .pin(s_q.pin),
        .take(take)
    );

    function automatic logic [31:0] reg_read(
        input logic [7:0] a,
        input bct_pkg::bct_core_s s
    );
        logic [31:0] r;
        r = 32'h0000_0000;
        case (a)
            bct_pkg::ADDR_FLAGS: r[7:0] = s.flags;
            bct_pkg::ADDR_PC: r[15:0] = s.pc;
            bct_pkg::ADDR_ACC: r[7:0] = s.acc;
            bct_pkg::ADDR_OPND: r[7:0] = s.opnd;
            bct_pkg::ADDR_CMD: r[15:0] = s.cmd;
            bct_pkg::ADDR_STATUS: begin
                r[bct_pkg::STAT_BUSY] = s.busy;
                r[bct_pkg::STAT_TAKEN] = s.taken;
                r[bct_pkg::STAT_OVERRUN] = s.overrun;
                r[bct_pkg::STAT_ILLEGAL] = s.illegal;
            end
            default: r = 32'h0000_0000;
        endcase
        return r;
    endfunction

    function automatic logic is_mapped(input logic [7:0] a);
        return (a == bct_pkg::ADDR_FLAGS) || (a == bct_pkg::ADDR_PC) ||
               (a == bct_pkg::ADDR_ACC) || (a == bct_pkg::ADDR_OPND) ||
               (a == bct_pkg::ADDR_CMD);
    endfunction

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        s_d.ready = 1'b1;
        s_d.resp = 1'b0;
        go = 1'b0;
        new_op = HWDATA[7:0];
        and_res = s_q.acc & s_q.opnd;
        addr_ok = HSEL && HTRANS[1] && HREADY;

        // Address phase: latch the write target, prepare read data.
        s_d.wr_pend = addr_ok && HWRITE && (HSIZE == bct_pkg::SIZE_WORD);
        s_d.wr_addr = HADDR[7:0];
        if (addr_ok && !HWRITE) begin
            s_d.rdata = reg_read(HADDR[7:0], s_q);
        end

        // Data phase of a write.
        if (s_q.wr_pend) begin
            if (s_q.wr_addr == bct_pkg::ADDR_STATUS) begin
                if (HWDATA[bct_pkg::STAT_OVERRUN]) begin
                    s_d.overrun = 1'b0;
                end
                if (HWDATA[bct_pkg::STAT_ILLEGAL]) begin
                    s_d.illegal = 1'b0;
                end
            end else if (s_q.busy) begin
                // Machine state is frozen while an instruction runs, so a
                // write here would corrupt the result; drop it and record.
                if (is_mapped(s_q.wr_addr)) begin
                    s_d.overrun = 1'b1;
                end
            end else begin
                case (s_q.wr_addr)
                    bct_pkg::ADDR_FLAGS: begin
                        s_d.flags = bct_pkg::bct_ccr_s'(HWDATA[7:0] |
                                                        bct_pkg::FLAGS_ONES);
                    end
                    bct_pkg::ADDR_PC: s_d.pc = HWDATA[15:0];
                    bct_pkg::ADDR_ACC: s_d.acc = HWDATA[7:0];
                    bct_pkg::ADDR_OPND: s_d.opnd = HWDATA[7:0];
                    bct_pkg::ADDR_CMD: go = 1'b1;
                    default: go = 1'b0;
                endcase
            end
        end

        // Instruction start.
        if (go) begin
            s_d.cmd = HWDATA[15:0];
            if (bct_pkg::is_branch_op(new_op) || bct_pkg::is_bit_op(new_op))
            begin
                s_d.state = bct_pkg::ST_EXEC;
                s_d.busy = 1'b1;
                s_d.taken = 1'b0;
                s_d.pin = IRQ_PIN;
                s_d.is_bit = bct_pkg::is_bit_op(new_op);
                if (bct_pkg::is_bit_op(new_op)) begin
                    s_d.cnt = bct_pkg::BIT_CYCLES - 2'h1;
                end else begin
                    s_d.cnt = bct_pkg::BRANCH_CYCLES - 2'h1;
                end
            end else begin
                s_d.illegal = 1'b1;
            end
        end

        // Execution.
        unique case (s_q.state)
            bct_pkg::ST_IDLE: begin
            end
            bct_pkg::ST_EXEC: begin
                if (s_q.cnt != 2'h0) begin
                    s_d.cnt = s_q.cnt - 2'h1;
                end else begin
                    s_d.state = bct_pkg::ST_IDLE;
                    s_d.busy = 1'b0;
                    s_d.done = 1'b1;
                    if (s_q.is_bit) begin
                        // The AND result is not stored anywhere.
                        s_d.flags.v = 1'b0;
                        s_d.flags.n = and_res[7];
                        s_d.flags.z = (and_res == 8'h00);
                        s_d.taken = 1'b0;
                        s_d.pc = s_q.pc + bct_pkg::INSN_LEN;
                    end else if (take) begin
                        s_d.taken = 1'b1;
                        s_d.pc = s_q.pc + bct_pkg::INSN_LEN +
                                 bct_pkg::sext8(s_q.cmd.rel);
                    end else begin
                        s_d.taken = 1'b0;
                        s_d.pc = s_q.pc + bct_pkg::INSN_LEN;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            s_q <= bct_pkg::CORE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign HRDATA = s_q.rdata;
    assign HREADYOUT = s_q.ready;
    assign HRESP = s_q.resp;
    assign BUSY = s_q.busy;
    assign BRANCH_DONE = s_q.done;
    assign BRANCH_TAKEN = s_q.taken;
    assign NEXT_PC = s_q.pc;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RST_N);

    logic fin_op;
    assign fin_op = s_q.done && !s_q.is_bit;

    sequence s_branch_go;
        go && bct_pkg::is_branch_op(new_op);
    endsequence

    sequence s_branch_run;
        s_q.busy [*3] ##1 (!s_q.busy && s_q.done);
    endsequence

    a_branch_three_cycles: assert property (
        s_branch_go |=> s_branch_run
    ) else $error("branch did not take three cycles");

    a_branch_flags_kept: assert property (
        (s_q.busy && !s_q.is_bit) |=> (s_q.flags == $past(s_q.flags))
    ) else $error("branch changed a flag");

    a_taken_target_add: assert property (
        (s_q.done && s_q.taken) |-> (s_q.pc == 16'($past(s_q.pc) + 16'h0002
                                     + bct_pkg::sext8(s_q.cmd.rel)))
    ) else $error("taken branch target wrong");

    a_fall_through_next: assert property (
        (s_q.done && !s_q.taken) |-> (s_q.pc == 16'($past(s_q.pc) + 16'h0002))
    ) else $error("fall-through address wrong");

    a_higher_same_cond: assert property (
        (fin_op && s_q.cmd.op == 8'h24) |-> (s_q.taken == !s_q.flags.c)
    ) else $error("higher-or-same decision wrong");

    a_pin_high_cond: assert property (
        (fin_op && s_q.cmd.op == 8'h2f) |-> (s_q.taken == s_q.pin)
    ) else $error("pin-high decision wrong");

    a_pin_low_cond: assert property (
        (fin_op && s_q.cmd.op == 8'h2e) |-> (s_q.taken == !s_q.pin)
    ) else $error("pin-low decision wrong");

    a_bit_neg_ovf: assert property (
        (s_q.done && s_q.is_bit) |-> (!s_q.flags.v &&
            s_q.flags.n == (s_q.acc[7] & s_q.opnd[7]))
    ) else $error("bit test N or V wrong");

    a_bit_zero_keep: assert property (
        (s_q.done && s_q.is_bit) |-> (s_q.flags.z == ((s_q.acc & s_q.opnd)
            == 8'h00)) && $stable(s_q.acc) && $stable(s_q.opnd)
    ) else $error("bit test Z or operands wrong");

    a_less_equal_cond: assert property (
        (fin_op && s_q.cmd.op == 8'h93) |-> (s_q.taken == (s_q.flags.z ||
            (s_q.flags.n ^ s_q.flags.v)))
    ) else $error("signed less-equal decision wrong");

    a_lower_cond: assert property (
        (fin_op && s_q.cmd.op == 8'h25) |-> (s_q.taken == s_q.flags.c)
    ) else $error("unsigned lower decision wrong");

    a_lower_same_cond: assert property (
        (fin_op && s_q.cmd.op == 8'h23) |->
            (s_q.taken == (s_q.flags.c || s_q.flags.z))
    ) else $error("lower-or-same decision wrong");

    a_signed_less_cond: assert property (
        (fin_op && s_q.cmd.op == 8'h91) |->
            (s_q.taken == (s_q.flags.n ^ s_q.flags.v))
    ) else $error("signed less decision wrong");

    a_mask_clear_cond: assert property (
        (fin_op && s_q.cmd.op == 8'h2c) |-> (s_q.taken == !s_q.flags.i)
    ) else $error("mask-clear decision wrong");

endmodule // bct_top

// File: bench/bct_top_tb_top.sv
// Self-checking testbench for the branch-condition and bit-test unit.
`timescale 1ns/1ns

module bct_top_tb_top;
    // ---------------------------------------------------------------
    // Signals
    // ---------------------------------------------------------------
    logic clock, rst_n, hsel, hwrite, irq_pin;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic hreadyout, hresp, busy, done, taken;
    logic [15:0] next_pc;
    int bad_count = 0;
    int checks = 0;
    int cycles = 0;

    bct_top bct_top_i (
        .CLOCK(clock), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
        .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
        .HRESP(hresp), .IRQ_PIN(irq_pin), .BUSY(busy),
        .BRANCH_DONE(done), .BRANCH_TAKEN(taken), .NEXT_PC(next_pc)
    );

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // The longest run needs a few hundred cycles; this leaves margin.
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count = bad_count + 1;
            tally_and_finish();
        end
    end

    // ---------------------------------------------------------------
    // Shared tasks
    // ---------------------------------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        checks = checks + 1;
        if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Called just after a rising edge; returns just after the data phase.
    task automatic ahb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= 2'b10;
        hwrite <= wr;
        hsize <= bct_pkg::SIZE_WORD;
        do @(posedge clock); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clock); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        ahb(1'b1, a, d, x);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a,
                          input logic [31:0] exp);
        logic [31:0] x;
        ahb(1'b0, a, 32'h0000_0000, x);
        chk(what, exp, x);
    endtask

    // Starts an instruction and counts busy cycles up to its retire pulse.
    task automatic run_cmd(input logic [7:0] op, input logic [7:0] rel,
                           input int exp_busy, output logic [15:0] pc_seen,
                           output logic tk);
        int n;
        n = 0;
        wr(bct_pkg::ADDR_CMD, {16'h0000, rel, op});
        // The pin is only looked at on the command edge, so move it now.
        irq_pin <= ~irq_pin;
        for (int i = 0; i < 20; i++) begin
            @(posedge clock);
            if (done === 1'b1) break;
            if (busy === 1'b1) n++;
        end
        chk("busy cycles", 32'(exp_busy), 32'(n));
        chk("retire pulse", 32'h1, {31'h0, done});
        pc_seen = next_pc;
        tk = taken;
    endtask

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic branch(input logic [7:0] op, input logic [7:0] fl,
                          input logic pin, input logic [7:0] rel,
                          input logic exp_take);
        logic [15:0] pc, tgt, got;
        logic tk;
        // Both offsets are chosen to make the target wrap around.
        pc = rel[7] ? 16'h0010 : 16'hfff0;
        tgt = pc + 16'h0002;
        if (exp_take) tgt = tgt + {{8{rel[7]}}, rel};
        irq_pin <= pin;
        wr(bct_pkg::ADDR_FLAGS, {24'h00_0000, fl});
        wr(bct_pkg::ADDR_PC, {16'h0000, pc});
        run_cmd(op, rel, 3, got, tk);
        chk("branch taken", {31'h0, exp_take}, {31'h0, tk});
        chk("next pc", {16'h0000, tgt}, {16'h0000, got});
        rd_chk("flags kept", bct_pkg::ADDR_FLAGS,
               {24'h0, fl | bct_pkg::FLAGS_ONES});
    endtask

    task automatic bit_test(input logic [7:0] op, input logic [7:0] a,
                            input logic [7:0] m, input logic [7:0] fl);
        logic [7:0] r, ef;
        logic [15:0] got;
        logic tk;
        r = a & m;
        ef = (fl | 8'h60) & 8'h79;
        ef[2] = r[7];
        ef[1] = (r == 8'h00);
        wr(bct_pkg::ADDR_ACC, {24'h0, a});
        wr(bct_pkg::ADDR_OPND, {24'h0, m});
        wr(bct_pkg::ADDR_FLAGS, {24'h0, fl});
        wr(bct_pkg::ADDR_PC, 32'h0000_2000);
        run_cmd(op, 8'h10, 2, got, tk);
        chk("bit test taken", 32'h0, {31'h0, tk});
        chk("bit test pc", 32'h2002, {16'h0000, got});
        rd_chk("bit test flags", bct_pkg::ADDR_FLAGS, {24'h0, ef});
        rd_chk("acc kept", bct_pkg::ADDR_ACC, {24'h0, a});
        rd_chk("operand kept", bct_pkg::ADDR_OPND, {24'h0, m});
    endtask

    task automatic refusals();
        wr(bct_pkg::ADDR_ACC, 32'h11);
        wr(bct_pkg::ADDR_FLAGS, 32'h01);
        wr(bct_pkg::ADDR_CMD, {24'h0, bct_pkg::OP_HIGHER_SAME});
        wr(bct_pkg::ADDR_ACC, 32'h22);
        repeat (8) @(posedge clock);
        rd_chk("acc while busy", bct_pkg::ADDR_ACC, 32'h11);
        rd_chk("overrun flag", bct_pkg::ADDR_STATUS, 32'h4);
        wr(bct_pkg::ADDR_STATUS, 32'h4);
        rd_chk("overrun clear", bct_pkg::ADDR_STATUS, 32'h0);
        wr(bct_pkg::ADDR_CMD, 32'h20);
        repeat (8) @(posedge clock);
        chk("illegal busy", 32'h0, {31'h0, busy});
        rd_chk("illegal flag", bct_pkg::ADDR_STATUS, 32'h8);
        wr(bct_pkg::ADDR_STATUS, 32'h8);
        rd_chk("illegal clear", bct_pkg::ADDR_STATUS, 32'h0);
        rd_chk("unmapped read", 8'h40, 32'h0);
    endtask

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        hsel = 1'b0;
        hwrite = 1'b0;
        irq_pin = 1'b0;
        haddr = 32'h0;
        hwdata = 32'h0;
        htrans = 2'b00;
        hsize = 3'h2;
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        chk("reset ready", 32'h1, {31'h0, hreadyout});
        chk("reset resp", 32'h0, {31'h0, hresp});
        chk("reset busy", 32'h0, {31'h0, busy});
        chk("reset pc", 32'h0, {16'h0, next_pc});
        rd_chk("reset flags", bct_pkg::ADDR_FLAGS, 32'h60);
        rd_chk("reset status", bct_pkg::ADDR_STATUS, 32'h0);
        branch(bct_pkg::OP_HIGHER_SAME, 8'h02, 1'b0, 8'h7f, 1'b1);
        branch(bct_pkg::OP_HIGHER_SAME, 8'h01, 1'b0, 8'h80, 1'b0);
        branch(bct_pkg::OP_UNSIGNED_LOWER, 8'h01, 1'b0, 8'h80, 1'b1);
        branch(bct_pkg::OP_UNSIGNED_LOWER, 8'h8e, 1'b1, 8'h7f, 1'b0);
        branch(bct_pkg::OP_LOWER_SAME, 8'h02, 1'b0, 8'h80, 1'b1);
        branch(bct_pkg::OP_LOWER_SAME, 8'h01, 1'b0, 8'h7f, 1'b1);
        branch(bct_pkg::OP_LOWER_SAME, 8'h9c, 1'b0, 8'h7f, 1'b0);
        branch(bct_pkg::OP_SIGNED_LESS, 8'h04, 1'b0, 8'h80, 1'b1);
        branch(bct_pkg::OP_SIGNED_LESS, 8'h80, 1'b0, 8'h7f, 1'b1);
        branch(bct_pkg::OP_SIGNED_LESS, 8'h86, 1'b0, 8'h80, 1'b0);
        branch(bct_pkg::OP_SIGNED_LESS_EQUAL, 8'h02, 1'b0, 8'h7f,
               1'b1);
        branch(bct_pkg::OP_SIGNED_LESS_EQUAL, 8'h80, 1'b0, 8'h80,
               1'b1);
        branch(bct_pkg::OP_SIGNED_LESS_EQUAL, 8'h85, 1'b0, 8'h7f,
               1'b0);
        branch(bct_pkg::OP_MASK_CLEAR, 8'h97, 1'b0, 8'h80, 1'b1);
        branch(bct_pkg::OP_MASK_CLEAR, 8'h08, 1'b0, 8'h7f, 1'b0);
        branch(bct_pkg::OP_PIN_HIGH, 8'h00, 1'b1, 8'h80, 1'b1);
        branch(bct_pkg::OP_PIN_HIGH, 8'h00, 1'b0, 8'h7f, 1'b0);
        branch(bct_pkg::OP_PIN_LOW, 8'h00, 1'b0, 8'h7f, 1'b1);
        branch(bct_pkg::OP_PIN_LOW, 8'h00, 1'b1, 8'h80, 1'b0);
        for (int k = 0; k < 6; k++) begin
            bit_test({4'(10 + k), 4'h5}, 8'hff, 8'h80 >> k,
                     8'h8f);
        end
        bit_test(8'ha5, 8'hf0, 8'h0f, 8'h80);
        bit_test(8'hb5, 8'h00, 8'h00, 8'h1e);
        refusals();
        tally_and_finish();
    end
endmodule // bct_top_tb_top
